// [hw/vdwd_pkg.sv]
// package: word layouts, status layouts and decode constants for the display word decoder
package vdwd_pkg;

  // ----------------------------------------
  // word geometry (bit 0 is the most significant bit)
  // ----------------------------------------
  localparam int WORD_W = 18;
  localparam logic [3:0] OP_CHAR = 4'h0;
  localparam logic [3:0] OP_STRING = 4'h1;
  localparam logic [3:0] OP_PLOT = 4'h3;
  localparam logic [5:0] OP_PARAM1 = 6'h10;
  localparam logic [5:0] OP_PARAM2 = 6'h11;
  localparam logic [5:0] OP_PARAM3 = 6'h12;
  localparam logic [1:0] SEL_STATUS1 = 2'h1;
  localparam logic [1:0] SEL_STATUS2 = 2'h2;
  localparam logic [1:0] SEL_STATUS3 = 2'h3;

  // ----------------------------------------
  // reset values of the display settings
  // ----------------------------------------
  localparam logic [2:0] RST_BRIGHTNESS = 3'h0;
  localparam logic [3:0] RST_SCALE = 4'h0;
  localparam logic [1:0] RST_LINE = 2'h0;
  localparam logic [1:0] RST_ACCESS = 2'h0;
  localparam logic [1:0] RST_BUTTON_SET = 2'h0;

  typedef enum {
    VDWD_NONE,
    VDWD_CHAR,
    VDWD_STRING,
    VDWD_PLOT,
    VDWD_PARAM1,
    VDWD_PARAM2,
    VDWD_PARAM3,
    VDWD_OTHER
  } vdwd_kind_t;

  // ----------------------------------------
  // status words, fields listed from bit 0 downward
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] unused;
    logic offset_state;
    logic rotation_state;
    logic blink_state;
    logic [1:0] access_mode_sel;
    logic [3:0] scale_step;
    logic stop_ie;
    logic pen_ie;
    logic edge_ie;
    logic button_ie;
    logic pen_flag_enable;
    logic [1:0] line_pattern;
  } vdwd_status1_t;

  typedef struct packed {
    logic edge_flag_enable;
    logic [2:0] brightness_bit;
    logic [6:0] name_register_bit;
    logic [5:0] pushbutton_bit;
    logic unused;
  } vdwd_status2_t;

  typedef struct packed {
    logic stop_flag;
    logic button_find_flag;
    logic [1:0] unused_a;
    logic ext_stop_flag;
    logic arb_state;
    logic [11:0] unused_b;
  } vdwd_status3_t;

  // control word written by the host
  typedef struct packed {
    logic [4:0] set_flag;
    logic [4:0] clr_flag;
    logic access_change;
    logic [1:0] access_mode_sel;
    logic pen_intr_clr;
    logic [1:0] button_set_sel;
    logic pen_flag_en_set;
    logic pen_flag_en_clr;
  } vdwd_control_t;

  // flag order inside set/clear groups
  localparam int FLG_STOP = 4;
  localparam int FLG_PEN = 3;
  localparam int FLG_EDGE = 2;
  localparam int FLG_FIND = 1;
  localparam int FLG_EXT = 0;

  // decoded display command
  typedef struct packed {
    logic pen_flag_en;
    logic [7:0] char_code;
    logic indirect_select;
    logic [12:0] address;
    logic intensify;
    logic x_select;
    logic graph_select;
    logic [9:0] coord;
  } vdwd_cmd_t;

endpackage

// [hw/vdwd_word_class.sv]
// combinational classifier and field extractor for one display-file word
module vdwd_word_class (
  // word in
  input wire logic [0:17] word_i,
  // decoded
  output vdwd_pkg::vdwd_kind_t kind_o,
  output vdwd_pkg::vdwd_cmd_t cmd_o
);

  always_comb begin
    kind_o = vdwd_pkg::VDWD_OTHER;
    if (word_i[0:3] == vdwd_pkg::OP_CHAR) begin
      kind_o = vdwd_pkg::VDWD_CHAR;
    end else if (word_i[0:3] == vdwd_pkg::OP_STRING) begin
      kind_o = vdwd_pkg::VDWD_STRING;
    end else if (word_i[0:3] == vdwd_pkg::OP_PLOT && !word_i[5]) begin
      kind_o = vdwd_pkg::VDWD_PLOT;
    end else if (word_i[0:5] == vdwd_pkg::OP_PARAM1) begin
      kind_o = vdwd_pkg::VDWD_PARAM1;
    end else if (word_i[0:5] == vdwd_pkg::OP_PARAM2) begin
      kind_o = vdwd_pkg::VDWD_PARAM2;
    end else if (word_i[0:5] == vdwd_pkg::OP_PARAM3) begin
      kind_o = vdwd_pkg::VDWD_PARAM3;
    end
  end

  always_comb begin
    cmd_o.pen_flag_en = word_i[5];
    cmd_o.char_code = word_i[10:17];
    cmd_o.indirect_select = word_i[4];
    cmd_o.address = word_i[5:17];
    cmd_o.intensify = word_i[4];
    cmd_o.x_select = word_i[6];
    cmd_o.graph_select = word_i[7];
    cmd_o.coord = word_i[8:17];
  end

endmodule

// [hw/vdwd_decode.sv]
// display word decoder with settings, flags and the three host status words

// Behaviour
// - status one: offset, rotation, blink, mode, scale, enables
// - status two: edge enable, brightness, name, buttons
// - status three: stop, find, external stop, arbitration
// - control word sets, clears flags and settings
// - prefix 0000 is single character command
// - prefix 0001 is string, indirect, address
// - prefix 0011 with bit 5 clear is point or graph plot
// - six-bit prefixes select the three parameter commands
module vdwd_decode (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // display-file words from memory
  input wire logic word_valid_i,
  input wire logic [0:17] word_i,
  // host transfers
  input wire logic ctl_wr_i,
  input wire logic [0:17] ctl_data_i,
  input wire logic stat_rd_i,
  input wire logic [1:0] stat_sel_i,
  // console pins
  input wire logic pen_hit_i,
  input wire logic edge_hit_i,
  input wire logic button_find_i,
  input wire logic ext_stop_i,
  input wire logic arb_i,
  input wire logic [5:0] pushbutton_bit_i,
  input wire logic [6:0] name_register_bit_i,
  // status answer
  output logic stat_valid_o,
  output logic [0:17] stat_data_o,
  // decoded command
  output logic cmd_valid_o,
  output vdwd_pkg::vdwd_kind_t cmd_kind_o,
  output vdwd_pkg::vdwd_cmd_t cmd_o,
  output logic escape_enable_o,
  output logic escape_cr_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  logic [10:0] sync_prev;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_a <= 11'h000;
      sync_b <= 11'h000;
      sync_prev <= 11'h000;
    end else begin
      sync_a <= {pen_hit_i, edge_hit_i, button_find_i, ext_stop_i, arb_i, pushbutton_bit_i};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  logic pen_rise;
  logic edge_rise;
  logic find_rise;
  logic ext_rise;
  assign pen_rise = sync_b[10] & ~sync_prev[10];
  assign edge_rise = sync_b[9] & ~sync_prev[9];
  assign find_rise = sync_b[8] & ~sync_prev[8];
  assign ext_rise = sync_b[7] & ~sync_prev[7];

  // ----------------------------------------
  // word decode
  // ----------------------------------------
  vdwd_pkg::vdwd_kind_t kind;
  vdwd_pkg::vdwd_cmd_t cmd;

  vdwd_word_class u_class (
    .word_i(word_i),
    .kind_o(kind),
    .cmd_o(cmd)
  );

  logic is_p1;
  logic is_p2;
  logic is_p3;
  assign is_p1 = word_valid_i && kind == vdwd_pkg::VDWD_PARAM1;
  assign is_p2 = word_valid_i && kind == vdwd_pkg::VDWD_PARAM2;
  assign is_p3 = word_valid_i && kind == vdwd_pkg::VDWD_PARAM3;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_kind_o <= vdwd_pkg::VDWD_NONE;
      cmd_o <= '0;
    end else begin
      cmd_valid_o <= word_valid_i;
      if (word_valid_i) begin
        cmd_kind_o <= kind;
        cmd_o <= cmd;
      end
    end
  end

  // ----------------------------------------
  // display settings
  // ----------------------------------------
  logic [2:0] brightness_bit;
  logic [3:0] scale_step;
  logic blink_state;
  logic edge_flag_enable;
  logic rotation_state;
  logic offset_state;
  logic pen_flag_enable;
  logic stop_ie;
  logic pen_ie;
  logic edge_ie;
  logic button_ie;
  logic [1:0] line_pattern;
  logic [1:0] access_mode_sel;
  logic [1:0] button_set_sel;
  vdwd_pkg::vdwd_control_t ctl;
  assign ctl = ctl_data_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      brightness_bit <= vdwd_pkg::RST_BRIGHTNESS;
      scale_step <= vdwd_pkg::RST_SCALE;
      escape_enable_o <= 1'b0;
      escape_cr_o <= 1'b0;
      blink_state <= 1'b0;
      edge_flag_enable <= 1'b0;
      rotation_state <= 1'b0;
      offset_state <= 1'b0;
    end else if (is_p1) begin
      brightness_bit <= word_i[8:10];
      if (word_i[13]) begin
        scale_step <= word_i[14:17];
      end
    end else if (is_p2) begin
      if (word_i[6]) begin
        escape_enable_o <= 1'b1;
        escape_cr_o <= word_i[7];
      end
      if (word_i[8]) begin
        blink_state <= word_i[9];
      end
      if (word_i[10]) begin
        edge_flag_enable <= word_i[11];
      end
      if (word_i[12]) begin
        rotation_state <= word_i[13];
      end
      if (word_i[16]) begin
        offset_state <= word_i[17];
      end
    end
  end

  // pen flag enable is shared by parameter two and the control word
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pen_flag_enable <= 1'b0;
    end else if (ctl_wr_i && (ctl.pen_flag_en_set || ctl.pen_flag_en_clr)) begin
      pen_flag_enable <= ctl.pen_flag_en_set;
    end else if (is_p2 && word_i[14]) begin
      pen_flag_enable <= word_i[15];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stop_ie <= 1'b0;
      pen_ie <= 1'b0;
      edge_ie <= 1'b0;
      button_ie <= 1'b0;
      line_pattern <= vdwd_pkg::RST_LINE;
    end else if (is_p1) begin
      stop_ie <= word_i[7];
    end else if (is_p3) begin
      if (word_i[10]) begin
        stop_ie <= word_i[11];
        pen_ie <= word_i[12];
        edge_ie <= word_i[13];
        button_ie <= word_i[14];
      end
      if (word_i[15]) begin
        line_pattern <= word_i[16:17];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      access_mode_sel <= vdwd_pkg::RST_ACCESS;
      button_set_sel <= vdwd_pkg::RST_BUTTON_SET;
    end else if (ctl_wr_i) begin
      if (ctl.access_change) begin
        access_mode_sel <= ctl.access_mode_sel;
      end
      button_set_sel <= ctl.button_set_sel;
    end
  end

  // ----------------------------------------
  // event flags: a set in the same cycle as a clear wins
  // ----------------------------------------
  logic [4:0] flags;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  always_comb begin
    flag_set = 5'h00;
    flag_clr = 5'h00;
    flag_set[vdwd_pkg::FLG_STOP] = is_p1 & word_i[6];
    flag_set[vdwd_pkg::FLG_PEN] = pen_rise & pen_flag_enable;
    flag_set[vdwd_pkg::FLG_EDGE] = edge_rise & edge_flag_enable;
    flag_set[vdwd_pkg::FLG_FIND] = find_rise;
    flag_set[vdwd_pkg::FLG_EXT] = ext_rise;
    if (ctl_wr_i) begin
      flag_set = flag_set | ctl.set_flag;
      flag_clr = ctl.clr_flag;
      flag_clr[vdwd_pkg::FLG_PEN] = ctl.clr_flag[vdwd_pkg::FLG_PEN] | ctl.pen_intr_clr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flags <= 5'h00;
    end else begin
      flags <= flag_set | (flags & ~flag_clr);
    end
  end

  // ----------------------------------------
  // status words
  // ----------------------------------------
  vdwd_pkg::vdwd_status1_t st1;
  vdwd_pkg::vdwd_status2_t st2;
  vdwd_pkg::vdwd_status3_t st3;

  always_comb begin
    st1 = '0;
    st1.offset_state = offset_state;
    st1.rotation_state = rotation_state;
    st1.blink_state = blink_state;
    st1.access_mode_sel = access_mode_sel;
    st1.scale_step = scale_step;
    st1.stop_ie = stop_ie;
    st1.pen_ie = pen_ie;
    st1.edge_ie = edge_ie;
    st1.button_ie = button_ie;
    st1.pen_flag_enable = pen_flag_enable;
    st1.line_pattern = line_pattern;
    st2 = '0;
    st2.edge_flag_enable = edge_flag_enable;
    st2.brightness_bit = brightness_bit;
    st2.name_register_bit = name_register_bit_i;
    st2.pushbutton_bit = sync_b[5:0];
    st3 = '0;
    st3.stop_flag = flags[vdwd_pkg::FLG_STOP];
    st3.button_find_flag = flags[vdwd_pkg::FLG_FIND];
    st3.ext_stop_flag = flags[vdwd_pkg::FLG_EXT];
    st3.arb_state = sync_b[6];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat_valid_o <= 1'b0;
      stat_data_o <= 18'h00000;
    end else begin
      stat_valid_o <= stat_rd_i;
      if (stat_rd_i) begin
        case (stat_sel_i)
          vdwd_pkg::SEL_STATUS1: stat_data_o <= st1;
          vdwd_pkg::SEL_STATUS2: stat_data_o <= st2;
          vdwd_pkg::SEL_STATUS3: stat_data_o <= st3;
          default: stat_data_o <= 18'h00000;
        endcase
      end
    end
  end

endmodule

// [testbench/vdwd_decode_asserts.sv]
// checker: timing and decode relations at the decoder ports
module vdwd_decode_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // requests
  input wire logic word_valid_i,
  input wire logic [0:17] word_i,
  input wire logic stat_rd_i,
  input wire logic [1:0] stat_sel_i,
  // answers
  input wire logic stat_valid_o,
  input wire logic [0:17] stat_data_o,
  input wire logic cmd_valid_o,
  input var vdwd_pkg::vdwd_kind_t cmd_kind_o,
  input wire vdwd_pkg::vdwd_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  stat_answer_a: assert property (stat_rd_i |=> stat_valid_o)
    else $error("status answer missing");
  stat_cause_a: assert property (stat_valid_o |-> $past(stat_rd_i))
    else $error("status answer without request");
  stat_hold_a: assert property (!stat_rd_i |=> $stable(stat_data_o))
    else $error("status data changed without read");
  sel_zero_a: assert property (stat_rd_i && stat_sel_i == 2'h0 |=> stat_data_o == 18'h00000)
    else $error("select zero not read as zero");
  cmd_answer_a: assert property (word_valid_i |=> cmd_valid_o)
    else $error("decode answer missing");
  cmd_cause_a: assert property (cmd_valid_o |-> $past(word_valid_i))
    else $error("decode answer without word");
  char_decode_a: assert property (word_valid_i && word_i[0:3] == vdwd_pkg::OP_CHAR |=>
    cmd_kind_o == vdwd_pkg::VDWD_CHAR && cmd_o.char_code == $past(word_i[10:17]))
    else $error("character word decoded wrongly");
  string_decode_a: assert property (word_valid_i && word_i[0:3] == vdwd_pkg::OP_STRING |=>
    cmd_kind_o == vdwd_pkg::VDWD_STRING && cmd_o.address == $past(word_i[5:17]))
    else $error("string word decoded wrongly");
  plot_decode_a: assert property (word_valid_i && word_i[0:3] == vdwd_pkg::OP_PLOT && !word_i[5] |=>
    cmd_kind_o == vdwd_pkg::VDWD_PLOT && cmd_o.coord == $past(word_i[8:17]))
    else $error("plot word decoded wrongly");
  bright_load_a: assert property (word_valid_i && word_i[0:5] == vdwd_pkg::OP_PARAM1 ##1 !word_valid_i
    ##1 stat_rd_i && stat_sel_i == vdwd_pkg::SEL_STATUS2 |=> stat_data_o[1:3] == $past(word_i[8:10], 3))
    else $error("brightness not loaded");

  cover property (word_valid_i && word_i[0:5] == vdwd_pkg::OP_PARAM2);
  cover property (stat_rd_i && stat_sel_i == vdwd_pkg::SEL_STATUS3);
  cover property (word_valid_i && word_i[0:3] == vdwd_pkg::OP_CHAR);
endmodule

bind vdwd_decode vdwd_decode_asserts chk_u (.sys_clk_i, .rst_i, .word_valid_i, .word_i, .stat_rd_i,
  .stat_sel_i, .stat_valid_o, .stat_data_o, .cmd_valid_o, .cmd_kind_o, .cmd_o);

// [testbench/vdwd_host_model.sv]
// host model: control writes and status reads over the transfer pins
module vdwd_host_model (
  // clock
  input wire logic sys_clk_i,
  // status answer
  input wire logic stat_valid_i,
  input wire logic [0:17] stat_data_i,
  // requests
  output logic ctl_wr_o,
  output logic [0:17] ctl_data_o,
  output logic stat_rd_o,
  output logic [1:0] stat_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ctl_wr_o = 1'b0;
    ctl_data_o = 18'h00000;
    stat_rd_o = 1'b0;
    stat_sel_o = 2'h0;
  end
  task automatic write_ctl(input logic [0:17] d);
    @(posedge sys_clk_i);
    #1;
    ctl_wr_o = 1'b1;
    ctl_data_o = d;
    @(posedge sys_clk_i);
    #1;
    ctl_wr_o = 1'b0;
    // unqualified data must not look like a held value
    ctl_data_o = ~d;
  endtask
  task automatic read_stat(input logic [1:0] sel, output logic [0:17] d);
    int n;
    @(posedge sys_clk_i);
    #1;
    stat_rd_o = 1'b1;
    stat_sel_o = sel;
    @(posedge sys_clk_i);
    #1;
    stat_rd_o = 1'b0;
    stat_sel_o = ~sel;
    n = 0;
    while (stat_valid_i !== 1'b1 && n < 4) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    // a missing answer hands back unknown data, so the caller's compare counts it
    if (stat_valid_i !== 1'b1) begin
      d = 'x;
    end else begin
      d = stat_data_i;
    end
  endtask
endmodule

// [testbench/vector_display_word_decode_test.sv]
// testbench: word decode, parameter settings, control word and status reads
module vector_display_word_decode_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, rst_i, word_valid_i, ctl_wr_i, stat_rd_i, stat_valid_o, cmd_valid_o;
  logic escape_enable_o, escape_cr_o, pen_hit_i, edge_hit_i, button_find_i, ext_stop_i, arb_i;
  logic [0:17] word_i, ctl_data_i, stat_data_o, rd;
  logic [1:0] stat_sel_i;
  logic [5:0] pushbutton_bit_i;
  logic [6:0] name_register_bit_i;
  vdwd_pkg::vdwd_kind_t cmd_kind_o;
  vdwd_pkg::vdwd_cmd_t cmd_o;
  vdwd_pkg::vdwd_status1_t s1;
  vdwd_pkg::vdwd_status2_t s2;
  int err_total = 0;
  int cmp_count = 0;

  vdwd_decode dut_u (.sys_clk_i, .rst_i, .word_valid_i, .word_i, .ctl_wr_i, .ctl_data_i, .stat_rd_i,
    .stat_sel_i, .pen_hit_i, .edge_hit_i, .button_find_i, .ext_stop_i, .arb_i, .pushbutton_bit_i,
    .name_register_bit_i, .stat_valid_o, .stat_data_o, .cmd_valid_o, .cmd_kind_o, .cmd_o,
    .escape_enable_o, .escape_cr_o);
  vdwd_host_model host_u (.sys_clk_i, .stat_valid_i(stat_valid_o), .stat_data_i(stat_data_o),
    .ctl_wr_o(ctl_wr_i), .ctl_data_o(ctl_data_i), .stat_rd_o(stat_rd_i), .stat_sel_o(stat_sel_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [0:17] exp, input logic [0:17] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rs(input logic [1:0] sel, input logic [0:17] exp);
    host_u.read_stat(sel, rd);
    chk("status", exp, rd);
  endtask
  task automatic send(input logic [0:17] w, input vdwd_pkg::vdwd_kind_t k);
    @(posedge sys_clk_i);
    #1;
    word_valid_i = 1'b1;
    word_i = w;
    @(posedge sys_clk_i);
    #1;
    word_valid_i = 1'b0;
    word_i = ~w;
    chk("cmd_valid", 18'h00001, {17'h00000, cmd_valid_o});
    chk("kind", 18'(k), 18'(cmd_kind_o));
  endtask

  initial begin
    #5000;
    err_total++;
    final_report;
  end

  initial begin
    {word_valid_i, pen_hit_i, edge_hit_i, button_find_i, ext_stop_i, arb_i} = 6'h00;
    word_i = 18'h00000;
    pushbutton_bit_i = 6'h00;
    name_register_bit_i = 7'h00;
    s1 = '0;
    s2 = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    // the host has started the processor: display-file words flow from here on
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) rs(2'(i), 18'h00000);
    send(18'h000C4, vdwd_pkg::VDWD_CHAR);
    chk("char_code", 18'h000C4, 18'(cmd_o.char_code));
    send(18'h07001, vdwd_pkg::VDWD_STRING);
    chk("address", 18'h03001, {4'h0, cmd_o.indirect_select, cmd_o.address});
    send(18'h0C980, vdwd_pkg::VDWD_PLOT);
    chk("plot", 18'h00980, {5'h00, cmd_o.intensify, cmd_o.x_select, cmd_o.graph_select, cmd_o.coord});
    send(18'h0D000, vdwd_pkg::VDWD_OTHER);
    send(18'h3F000, vdwd_pkg::VDWD_OTHER);
    send(18'h10698, vdwd_pkg::VDWD_PARAM1);
    s2.brightness_bit = 3'h5;
    rs(vdwd_pkg::SEL_STATUS2, s2);
    s1.scale_step = 4'h8;
    s1.stop_ie = 1'b1;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    // scale enable off: scale must survive while brightness moves
    send(18'h1010F, vdwd_pkg::VDWD_PARAM1);
    s1.stop_ie = 1'b0;
    s2.brightness_bit = 3'h2;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    send(18'h113AA, vdwd_pkg::VDWD_PARAM2);
    s1.blink_state = 1'b1;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    send(18'h11C00, vdwd_pkg::VDWD_PARAM2);
    rs(vdwd_pkg::SEL_STATUS1, s1);
    chk("escape", 18'h00003, {16'h0000, escape_enable_o, escape_cr_o});
    send(18'h12007, vdwd_pkg::VDWD_PARAM3);
    s1.line_pattern = 2'h3;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    send(18'h120F8, vdwd_pkg::VDWD_PARAM3);
    {s1.stop_ie, s1.pen_ie, s1.edge_ie, s1.button_ie} = 4'hF;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    host_u.write_ctl(18'h26000);
    rs(vdwd_pkg::SEL_STATUS3, 18'h32000);
    host_u.write_ctl(18'h01300);
    rs(vdwd_pkg::SEL_STATUS3, 18'h00000);
    host_u.write_ctl(18'h21000);
    rs(vdwd_pkg::SEL_STATUS3, 18'h20000);
    host_u.write_ctl(18'h000C2);
    s1.access_mode_sel = 2'h2;
    s1.pen_flag_enable = 1'b1;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    host_u.write_ctl(18'h01001);
    s1.pen_flag_enable = 1'b0;
    rs(vdwd_pkg::SEL_STATUS1, s1);
    @(posedge sys_clk_i);
    #1;
    {arb_i, ext_stop_i, button_find_i} = 3'h7;
    pushbutton_bit_i = 6'h2D;
    name_register_bit_i = 7'h55;
    // pins pass a two-stage synchroniser before the flags
    repeat (4) @(posedge sys_clk_i);
    rs(vdwd_pkg::SEL_STATUS3, 18'h13000);
    s2.name_register_bit = 7'h55;
    s2.pushbutton_bit = 6'h2D;
    rs(vdwd_pkg::SEL_STATUS2, s2);
    final_report;
  end
endmodule
